// *** core/sfc_frame_check.sv ***
// serial frame checker: clock count, crc check/generation, daisy chain
//
// Notes on behaviour
// - chain mode refuses all register access
// - chain frame: switch bits in, faults out
// - chain fault bits latched, clear next frame
// - fault bits filtered against lamp inrush
// - thermal shutdown forces all fault bits high
// - chain share 8 clocks, 16 with crc
// - clock count multiple of 8, minimum enforced
// - wrong count discards command, flags error
// - addressed lengths 16/24/32/40/56/64 per command
// - crc protection follows check enable input
// - crc5 poly x5+x4+x2+1, seed all ones
// - matching crc applies switches and config
// - crc mismatch keeps state, pulls error low
// - addressed check byte: address, thermal, crc
// - thermal flag set after shutdown event
// - chain check byte carries watchdog flag
// - supply flag mirrors supply summary bit
// - burst read returns six bytes, check, release
module sfc_frame_check
   import sfc_pkg::*;
#(
   parameter int unsigned LAMP_FILT_US = 4000
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        link_clk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   output logic             comm_error_output,
   output logic             comm_error_oe,
   input  wire logic        daisy_mode,
   input  wire logic        check_enable_input,
   input  wire logic        chip_address_bit1,
   input  wire logic        chip_address_bit0,
   input  wire logic [7:0]  channel_overload_flag,
   input  wire logic        thermal_shutdown,
   input  wire logic        supply_error_summary,
   input  wire logic        link_wd_expired,
   input  wire logic        update_wd_expired,
   input  wire logic [5:0]  status_summary,
   input  wire logic [47:0] diag_bytes,
   output logic [7:0]       switch_on,
   output logic             wr_valid,
   output sfc_wr_s          wr_cmd
);
   // filter length in sys cycles; lamp inrush must outlast none of it
   localparam int unsigned FILT_CYC = LAMP_FILT_US * SFC_SYS_MHZ;
   localparam logic [23:0] FILT_MAX = 24'(FILT_CYC);

   // ---------------- link domain ----------------
   logic [15:0] link_cnt_reg;
   logic [63:0] link_hist_reg;
   logic [7:0]  cmd_reg;
   logic [4:0]  crc_tx_reg;
   logic        sdo_reg;
   logic        in_frame_reg;
   // quasi-static words written by sys domain while the link clock stands
   logic [15:0] start_reg;
   logic [63:0] tx_reg;
   sfc_flags_s  flags_reg;
   logic        mode_daisy_reg;
   logic        check_en_reg;

   logic [15:0] j;
   logic [15:0] share;
   logic [15:0] chk_pos;
   logic [7:0]  cmd_now;
   logic        bit_j;
   logic        crc_take;
   logic [4:0]  crc_base;
   logic [15:0] k;

   // free running count; frame length is a difference, so no frame reset
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         link_cnt_reg  <= 16'h0000;
         link_hist_reg <= 64'h0;
      end else begin
         link_cnt_reg  <= link_cnt_reg + 16'h0001;
         link_hist_reg <= {link_hist_reg[62:0], sdi};
      end
   end

   always_comb begin
      j        = 16'(link_cnt_reg - start_reg);
      share    = check_en_reg ? SFC_SHARE_CRC : SFC_SHARE;
      cmd_now  = (j == SFC_BYTE) ? link_hist_reg[7:0] : cmd_reg;
      chk_pos  = mode_daisy_reg ? SFC_BYTE
               : 16'(sfc_addr_len(cmd_now, check_en_reg) - SFC_BYTE);
      k        = 16'(j - chk_pos);
      crc_take = 1'b0;
      bit_j    = 1'b0;
      if (mode_daisy_reg && j >= share) begin
         bit_j = link_hist_reg[6'(share - 16'h0001)];
      end else if (check_en_reg && (mode_daisy_reg || j >= SFC_BYTE)
                   && j >= chk_pos && k < SFC_FLAG_BITS) begin
         bit_j    = flags_reg[2'(SFC_FLAG_BITS - 16'h0001 - k)];
         crc_take = 1'b1;
      end else if (check_en_reg && (mode_daisy_reg || j >= SFC_BYTE)
                   && j >= chk_pos
                   && k < SFC_FLAG_BITS + SFC_CRC_BITS) begin
         bit_j = crc_tx_reg[3'(SFC_FLAG_BITS + SFC_CRC_BITS
                               - 16'h0001 - k)];
      end else if (j < 16'(SFC_HIST_W)) begin
         bit_j    = tx_reg[6'(16'(SFC_HIST_W) - 16'h0001 - j)];
         crc_take = 1'b1;
      end
      // first bit never passes a falling edge, fold it in at bit one
      crc_base = (j == 16'h0001) ? sfc_crc_step(SFC_CRC_INIT, tx_reg[63])
               : crc_tx_reg;
   end

   always_ff @(negedge link_clk or posedge rst) begin
      if (rst) begin
         cmd_reg    <= 8'h00;
         crc_tx_reg <= SFC_CRC_INIT;
         sdo_reg    <= 1'b0;
      end else begin
         if (j == SFC_BYTE) begin
            cmd_reg <= link_hist_reg[7:0];
         end
         crc_tx_reg <= crc_take ? sfc_crc_step(crc_base, bit_j)
                     : crc_base;
         sdo_reg    <= bit_j;
      end
   end

   // ended by the frame's own select, so no edge after the frame is needed
   always_ff @(negedge link_clk or posedge cs_n) begin
      if (cs_n) begin
         in_frame_reg <= 1'b0;
      end else begin
         in_frame_reg <= 1'b1;
      end
   end

   // bit zero must stand before the first edge, hence the select
   assign sdo = in_frame_reg ? sdo_reg : tx_reg[63];

   // ---------------- sys domain ----------------
   logic        cs_s1, cs_s2, cs_s3, cs_s4;
   logic [15:0] cnt_s1, cnt_s2;
   logic [63:0] hist_s1, hist_s2;
   logic [17:0] pin_s1, pin_s2;
   logic        eval_pulse;
   logic        cs_fall;
   logic [7:0]  ovl_s;
   logic        daisy_s, crc_s, a1_s, a0_s, therm_s, supply_s, wd_s;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {cs_s1, cs_s2, cs_s3, cs_s4} <= 4'hf;
         cnt_s1  <= 16'h0000;
         cnt_s2  <= 16'h0000;
         hist_s1 <= 64'h0;
         hist_s2 <= 64'h0;
         pin_s1  <= 18'h00000;
         pin_s2  <= 18'h00000;
      end else begin
         {cs_s1, cs_s2, cs_s3, cs_s4} <= {cs_n, cs_s1, cs_s2, cs_s3};
         cnt_s1  <= link_cnt_reg;
         cnt_s2  <= cnt_s1;
         hist_s1 <= link_hist_reg;
         hist_s2 <= hist_s1;
         pin_s1  <= {daisy_mode, check_enable_input, chip_address_bit1,
                     chip_address_bit0, thermal_shutdown,
                     supply_error_summary,
                     link_wd_expired | update_wd_expired,
                     channel_overload_flag, 3'h0};
         pin_s2  <= pin_s1;
      end
   end

   assign {daisy_s, crc_s, a1_s, a0_s, therm_s, supply_s, wd_s} =
          pin_s2[17:11];
   assign ovl_s      = pin_s2[10:3];
   // one stage late so the counts have settled past the crossing
   assign eval_pulse = cs_s3 & ~cs_s4;
   assign cs_fall    = ~cs_s2 & cs_s3;

   // lamp inrush filter, one counter per channel
   logic [7:0] filt;
   for (genvar c = 0; c < 8; c++) begin : g_filt
      logic [23:0] fcnt_reg;
      always_ff @(posedge clk_sys) begin
         if (rst || !ovl_s[c]) begin
            fcnt_reg <= 24'h000000;
         end else if (fcnt_reg != FILT_MAX) begin
            fcnt_reg <= fcnt_reg + 24'h000001;
         end
      end
      assign filt[c] = (fcnt_reg == FILT_MAX);
   end

   logic [7:0] latch_reg;
   logic       therm_seen_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         latch_reg      <= 8'h00;
         therm_seen_reg <= 1'b0;
      end else if (cs_fall) begin
         latch_reg      <= filt;
         therm_seen_reg <= therm_s;
      end else begin
         latch_reg      <= latch_reg | filt;
         therm_seen_reg <= therm_seen_reg | therm_s;
      end
   end

   // outgoing words load only while select is high
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_reg      <= 16'h0000;
         tx_reg         <= 64'h0;
         flags_reg      <= '0;
         mode_daisy_reg <= 1'b0;
         check_en_reg   <= 1'b0;
      end else if (cs_s2 && cs_s4) begin
         start_reg      <= cnt_s2;
         mode_daisy_reg <= daisy_s;
         check_en_reg   <= crc_s;
         if (daisy_s) begin
            tx_reg    <= {therm_s ? 8'hff : latch_reg, 56'h0};
            flags_reg <= '{watchdog_comm_flag: wd_s,
                           supply_error_flag: supply_s,
                           thermal_shutdown_flag: therm_seen_reg};
         end else begin
            tx_reg    <= {2'h0, status_summary, diag_bytes, 8'h00};
            flags_reg <= {a1_s, a0_s, therm_seen_reg};
         end
      end
   end

   // frame evaluation
   logic [15:0] len;
   logic [7:0]  cmd_rx;
   logic [15:0] own;
   logic        len_ok, crc_ok, chip_hit, burst_bad;
   logic [63:0] left;
   logic [1:0]  nbytes;

   always_comb begin
      len       = 16'(cnt_s2 - start_reg);
      cmd_rx    = 8'(hist_s2 >> 6'(len - SFC_BYTE));
      own       = hist_s2[15:0];
      left      = hist_s2 << 7'(16'(SFC_HIST_W) + SFC_BYTE - len);
      nbytes    = 2'((len - SFC_BYTE - (check_en_reg ? SFC_BYTE : 16'h0))
                     >> 3);
      chip_hit  = cmd_rx[SFC_CMD_CHIP_HI:SFC_CMD_CHIP_LO] == {a1_s, a0_s};
      burst_bad = cmd_rx[SFC_CMD_BURST_FLAG] && !cmd_rx[SFC_CMD_WR]
                  && cmd_rx[SFC_CMD_REG_HI:SFC_CMD_REG_LO] != SFC_BURST_ADDR;
      if (mode_daisy_reg) begin
         len_ok = len >= SFC_SHARE && len[2:0] == 3'h0
                  && !(check_en_reg && len[3]);
         crc_ok = !check_en_reg
                  || sfc_crc_over({48'h0, own} >> 5, SFC_DAISY_CHK_N)
                     == own[4:0];
      end else begin
         len_ok = len >= SFC_LEN_MIN && len[2:0] == 3'h0
                  && (len == sfc_addr_len(cmd_rx, check_en_reg)
                      || (cmd_rx[SFC_CMD_BURST_FLAG] && cmd_rx[SFC_CMD_WR]
                          && len == 16'(sfc_addr_len(cmd_rx, check_en_reg)
                                        + SFC_BYTE)));
         crc_ok = !check_en_reg
                  || sfc_crc_over(hist_s2 >> 5, 7'(len - SFC_CRC_BITS))
                     == hist_s2[4:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         switch_on     <= 8'h00;
         wr_valid      <= 1'b0;
         wr_cmd        <= '0;
         comm_error_oe <= 1'b0;
      end else begin
         wr_valid <= 1'b0;
         if (eval_pulse) begin
            if (mode_daisy_reg) begin
               if (len_ok && crc_ok) begin
                  // no register path exists in chain mode
                  switch_on     <= check_en_reg ? own[15:8] : own[7:0];
                  comm_error_oe <= 1'b0;
               end else begin
                  comm_error_oe <= 1'b1;
               end
            end else if (chip_hit) begin
               if (len_ok && crc_ok && !burst_bad) begin
                  comm_error_oe <= 1'b0;
                  if (cmd_rx[SFC_CMD_WR]) begin
                     wr_valid <= 1'b1;
                     wr_cmd   <= '{addr: cmd_rx[SFC_CMD_REG_HI:SFC_CMD_REG_LO],
                                   nbytes: nbytes,
                                   data: left[63:40]};
                  end
               end else begin
                  comm_error_oe <= 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sdo_oe            <= 1'b0;
         comm_error_output <= 1'b0;
      end else begin
         sdo_oe            <= ~cs_s2;
         comm_error_output <= 1'b0;
      end
   end
endmodule : sfc_frame_check

// *** include/sfc_pkg.sv ***
// constants, carriers and crc helpers for the serial frame checker
package sfc_pkg;
   localparam int unsigned SFC_SYS_MHZ     = 200;
   localparam int unsigned SFC_CNT_W       = 16;
   localparam int unsigned SFC_HIST_W      = 64;
   localparam logic [15:0] SFC_BYTE        = 16'h0008;
   localparam logic [15:0] SFC_SHARE       = 16'h0008;
   localparam logic [15:0] SFC_SHARE_CRC   = 16'h0010;
   localparam logic [15:0] SFC_LEN_MIN     = 16'h0010;
   localparam logic [15:0] SFC_LEN_ONE     = 16'h0010;
   localparam logic [15:0] SFC_LEN_ONE_CRC = 16'h0018;
   localparam logic [15:0] SFC_LEN_BW      = 16'h0018;
   localparam logic [15:0] SFC_LEN_BW_CRC  = 16'h0020;
   localparam logic [15:0] SFC_LEN_BR      = 16'h0038;
   localparam logic [15:0] SFC_LEN_BR_CRC  = 16'h0040;
   localparam logic [15:0] SFC_CRC_BITS    = 16'h0005;
   localparam logic [15:0] SFC_FLAG_BITS   = 16'h0003;
   localparam logic [6:0]  SFC_DAISY_CHK_N = 7'h0b;
   localparam logic [4:0]  SFC_CRC_INIT    = 5'h1f;
   localparam logic [4:0]  SFC_CRC_POLY    = 5'h15;
   localparam logic [3:0]  SFC_BURST_ADDR  = 4'h4;
   // command byte fields
   localparam int unsigned SFC_CMD_CHIP_HI = 7;
   localparam int unsigned SFC_CMD_CHIP_LO = 6;
   localparam int unsigned SFC_CMD_BURST_FLAG    = 5;
   localparam int unsigned SFC_CMD_REG_HI  = 4;
   localparam int unsigned SFC_CMD_REG_LO  = 1;
   localparam int unsigned SFC_CMD_WR      = 0;

   typedef struct packed {
      logic       watchdog_comm_flag;
      logic       supply_error_flag;
      logic       thermal_shutdown_flag;
   } sfc_flags_s;

   typedef struct packed {
      logic [3:0]  addr;
      logic [1:0]  nbytes;
      logic [23:0] data;
   } sfc_wr_s;

   function automatic logic [4:0] sfc_crc_step(logic [4:0] c, logic b);
      logic fb;
      fb = c[4] ^ b;
      return {c[3:0], 1'b0} ^ (fb ? SFC_CRC_POLY : 5'h00);
   endfunction : sfc_crc_step

   // msb first over the low n bits of d
   function automatic logic [4:0] sfc_crc_over(logic [63:0] d, logic [6:0] n);
      logic [4:0] c;
      c = SFC_CRC_INIT;
      for (int i = 63; i >= 0; i--) begin
         if (i < int'(n)) begin
            c = sfc_crc_step(c, d[i]);
         end
      end
      return c;
   endfunction : sfc_crc_over

   // shortest valid addressed length for a command
   function automatic logic [15:0] sfc_addr_len(logic [7:0] cmd, logic crc);
      if (!cmd[SFC_CMD_BURST_FLAG]) begin
         return crc ? SFC_LEN_ONE_CRC : SFC_LEN_ONE;
      end
      if (cmd[SFC_CMD_WR]) begin
         return crc ? SFC_LEN_BW_CRC : SFC_LEN_BW;
      end
      return crc ? SFC_LEN_BR_CRC : SFC_LEN_BR;
   endfunction : sfc_addr_len
endpackage : sfc_pkg

// *** sim/sfc_frame_check_monitor.sv ***
// checker for the serial frame checker ports
module sfc_frame_check_monitor
   import sfc_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       cs_n,
   input wire logic       daisy_mode,
   input wire logic       sdo_oe,
   input wire logic       comm_error_output,
   input wire logic       comm_error_oe,
   input wire logic [7:0] switch_on,
   input wire logic       wr_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // a frame long enough that no evaluation can fall inside it
   sequence frame_run;
      (!cs_n) [*6];
   endsequence
   sequence idle_run;
      cs_n [*4];
   endsequence
   a_oe_idle_low: assert property (idle_run |-> !sdo_oe)
      else $error("sdo driven outside frame");
   a_oe_frame_high: assert property ((!cs_n) [*5] |-> sdo_oe)
      else $error("sdo not driven in frame");
   a_switch_hold: assert property (frame_run |-> $stable(switch_on))
      else $error("switch bits changed in frame");
   a_err_hold: assert property (frame_run |-> $stable(comm_error_oe))
      else $error("error line changed in frame");
   a_write_pulse: assert property (wr_valid |=> !wr_valid)
      else $error("write pulse too long");
   a_write_after: assert property (wr_valid |-> cs_n && $past(cs_n))
      else $error("write before frame end");
   a_write_no_err: assert property (wr_valid |-> !comm_error_oe)
      else $error("write with error set");
   a_chain_no_write: assert property (daisy_mode |-> !wr_valid)
      else $error("register write in chain mode");
   a_od_low_only: assert property (1'b1 |-> !comm_error_output)
      else $error("open drain data driven high");
endmodule : sfc_frame_check_monitor

bind sfc_frame_check sfc_frame_check_monitor sfc_frame_check_monitor_inst (
   .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .daisy_mode(daisy_mode),
   .sdo_oe(sdo_oe), .comm_error_output(comm_error_output),
   .comm_error_oe(comm_error_oe), .switch_on(switch_on),
   .wr_valid(wr_valid)
);

// *** sim/sfc_spi_host.sv ***
// spi host model driving chip select, link clock and data
module sfc_spi_host (
   output logic cs_n,
   output logic link_clk,
   output logic sdi,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [63:0] rx;
   initial begin
      cs_n = 1'b1;
      link_clk = 1'b0;
      sdi = 1'b0;
      rx = '0;
   end
   // msb first; clock stands still outside frames
   task automatic xfer(input logic [63:0] tx, input int n);
      rx = '0;
      cs_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = tx[i];
         #80 link_clk = 1'b1;
         rx[i] = sdo;
         #80 link_clk = 1'b0;
      end
      #80 cs_n = 1'b1;
      // released line has no pull: show inverse, not the last bit
      sdi = ~sdi;
      #100;
   endtask : xfer
endmodule : sfc_spi_host

// *** sim/sfc_frame_check_test.sv ***
// testbench for the serial frame checker
module sfc_frame_check_test
   import sfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] on, pulse, ovl;
      logic       th;
      logic [7:0] fault;
   } sfc_row_s;
   logic clk_sys = 1'b0, rst = 1'b1, cs_n, link_clk, sdi, sdo, sdo_oe;
   logic ce_out, ce_oe, dm = 1'b1, ce = 1'b0, a1 = 1'b1, a0 = 1'b0;
   logic [7:0] ovl = '0, switch_on;
   logic th = 1'b0, sup = 1'b0, lwd = 1'b0, wr_valid, wr_seen;
   logic [5:0] stat = 6'h2d;
   logic [47:0] diag = 48'h0123456789ab;
   logic [63:0] tx;
   sfc_wr_s wr_cmd, wr_got;
   int fail_count = 0, checks_done = 0;
   // lamp pulse of 100 cycles stays under the 200 cycle filter
   sfc_row_s rows [3] = '{'{8'ha5, 8'hff, 8'h00, 1'b0, 8'h00},
                          '{8'h3c, 8'h00, 8'h81, 1'b0, 8'h81},
                          '{8'hc3, 8'h00, 8'h81, 1'b1, 8'hff}};
   always #2.5 clk_sys = ~clk_sys;
   sfc_spi_host sfc_spi_host_inst (.cs_n(cs_n), .link_clk(link_clk),
      .sdi(sdi), .sdo(sdo_oe ? sdo : ~sdo));
   sfc_frame_check #(.LAMP_FILT_US(1)) sfc_frame_check_inst (
      .clk_sys(clk_sys), .rst(rst), .link_clk(link_clk), .cs_n(cs_n),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .comm_error_output(ce_out),
      .comm_error_oe(ce_oe), .daisy_mode(dm), .check_enable_input(ce),
      .chip_address_bit1(a1), .chip_address_bit0(a0),
      .channel_overload_flag(ovl), .thermal_shutdown(th),
      .supply_error_summary(sup), .link_wd_expired(lwd),
      .update_wd_expired(1'b0), .status_summary(stat),
      .diag_bytes(diag), .switch_on(switch_on), .wr_valid(wr_valid),
      .wr_cmd(wr_cmd));
   always @(posedge clk_sys) begin
      if (rst) begin
         wr_seen <= 1'b0;
      end else if (wr_valid === 1'b1) begin
         wr_seen <= 1'b1;
         wr_got  <= wr_cmd;
      end
   end
   function automatic logic [4:0] crc5(logic [63:0] d, int n);
      logic [4:0] c;
      c = 5'h1f;
      for (int i = n - 1; i >= 0; i--) begin
         c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? 5'h15 : 5'h00);
      end
      return c;
   endfunction : crc5
   function automatic logic [63:0] frame_check_sequence(logic [63:0] d, int n);
      return (d << 8) | 64'(crc5(d << 3, n + 3));
   endfunction : frame_check_sequence
   task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic restart(logic m, logic e);
      @(posedge clk_sys) #1;
      rst = 1'b1;
      dm = m;
      ce = e;
      repeat (6) @(posedge clk_sys);
      #1 rst = 1'b0;
      repeat (400) @(posedge clk_sys);
   endtask : restart
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   initial begin
      #200000;
      fail_count++;
      stop_test();
   end
   initial begin
      restart(1'b1, 1'b0);
      chk("reset outs", 0, {switch_on, ce_oe, ce_out, sdo_oe, wr_valid});
      foreach (rows[k]) begin
         @(posedge clk_sys) #1;
         ovl = rows[k].pulse;
         repeat (100) @(posedge clk_sys);
         #1 ovl = rows[k].ovl;
         th = rows[k].th;
         repeat (400) @(posedge clk_sys);
         sfc_spi_host_inst.xfer({56'h0, rows[k].on}, 8);
         chk("faults", rows[k].fault, sfc_spi_host_inst.rx[7:0]);
         chk("switch_on", rows[k].on, switch_on);
      end
      sfc_spi_host_inst.xfer(64'h0f0, 12);
      chk("count err", {8'hc3, 1'b1}, {switch_on, ce_oe});
      sfc_spi_host_inst.xfer(64'h0f, 8);
      chk("good frame", {8'h0f, 1'b0, 1'b0},
          {switch_on, ce_oe, wr_seen});
      th = 1'b0;
      ovl = '0;
      lwd = 1'b1;
      sup = 1'b1;
      restart(1'b1, 1'b1);
      sfc_spi_host_inst.xfer(frame_check_sequence(8'h5a, 8), 16);
      tx = sfc_spi_host_inst.rx;
      chk("crc chain", {8'h5a, 1'b0}, {switch_on, ce_oe});
      chk("chain flags", 11'h006, tx[15:5]);
      chk("chain fcs", crc5(tx >> 5, 11), tx[4:0]);
      sfc_spi_host_inst.xfer(frame_check_sequence(8'h66, 8) ^ 64'h1, 16);
      chk("bad crc", {8'h5a, 1'b1, 1'b0}, {switch_on, ce_oe, ce_out});
      restart(1'b0, 1'b0);
      sfc_spi_host_inst.xfer(64'ha8, 8);
      chk("short addr", 1'b1, ce_oe);
      restart(1'b0, 1'b1);
      tx = frame_check_sequence(64'ha8 << 48, 56);
      sfc_spi_host_inst.xfer(tx, 64);
      tx = sfc_spi_host_inst.rx;
      chk("burst data", {2'b00, stat, diag}, tx[63:8]);
      chk("burst flags", 3'b100, tx[7:5]);
      chk("burst fcs", crc5(tx >> 5, 59), tx[4:0]);
      chk("burst ok", 1'b0, ce_oe);
      sfc_spi_host_inst.xfer(frame_check_sequence(64'haa << 48, 56), 64);
      chk("burst addr", 1'b1, ce_oe);
      sfc_spi_host_inst.xfer(frame_check_sequence(16'h8196, 16), 24);
      chk("write", {1'b1, 4'h0, 2'h1, 8'h96, 1'b0},
          {wr_seen, wr_got.addr, wr_got.nbytes, wr_got.data[23:16],
           ce_oe});
      sfc_spi_host_inst.xfer(64'h4100, 16);
      chk("other chip", 1'b0, ce_oe);
      sfc_spi_host_inst.xfer(frame_check_sequence(24'ha11234, 24), 32);
      chk("burst write", {2'h2, 16'h1234, 1'b0},
          {wr_got.nbytes, wr_got.data[23:8], ce_oe});
      sfc_spi_host_inst.xfer(64'ha8 << 48, 56);
      chk("burst short", 1'b1, ce_oe);
      stop_test();
   end
endmodule : sfc_frame_check_test
